// [logic/pws_map.vh]
/*
  Constants of the PCM word serializer: word width, source codes and reset
  values. Assumes it is included by bare name from the design file.
*/
`ifndef PWS_MAP_VH
`define PWS_MAP_VH

// ==========================================================================
// Word layout
`define PWS_WORD_W      8
`define PWS_MSB         7

// ==========================================================================
// Source codes on src_sel
`define PWS_SRC_MUX     2'h0
`define PWS_SRC_CODER   2'h1
`define PWS_SRC_TEST    2'h2
`define PWS_SRC_NONE    2'h3

// ==========================================================================
// Reset values and test bit count
`define PWS_WORD_RST    8'h00
`define PWS_BIT_RST     1'h0
`define PWS_CNT_RST     4'h0
`define PWS_TEST_CNT    4'h8

`endif

// [logic/pws_serializer.v]
/*
  PCM word serializer: low-power digital multiplexer with monitored power
  switch and word drivers, eight-stage output register, NRZ code flip-flop
  and complement self test of the output register.
  Assumes the programmer drives its pulses and selects synchronously to clk
  and keeps them apart: a load never coincides with a shift or a gate.
*/
`timescale 1ns/1ps
`include "pws_map.vh"

// Overview of operation
// - Programmer picks channel or identification word
// - Power switch on only during load
// - One word driver active, gates eight bits
// - Register loads eight parallel lines, mux, coder or test word
// - No reset; zeros shift in behind
// - Serial output drives NRZ code flip-flop
// - NRZ flip-flop holds last bit during load
// - Load, gate and shift pulses act separately
// - Test word, then its complement, checked serially
// - Test words go out in the frame
// - Bit rate follows shift and gate pulses
// - Drivers and power switch are monitored
// - Fault on command without output or reverse
module pws_serializer #(
  parameter NCH   = 4,
  parameter SELW  = 3,
  parameter [7:0] TEST_WORD = 8'h5a
) (
  // Clock and reset
  input  wire                 clk,
  input  wire                 nrst,
  // Programmer timing
  input  wire                 load_pulse,
  input  wire                 gate_pulse,
  input  wire                 shift_pulse,
  input  wire [1:0]           src_sel,
  input  wire [SELW-1:0]      word_sel,
  input  wire                 test_inv,
  // Data words
  input  wire [NCH*8-1:0]     chan_data,
  input  wire [7:0]           id_word,
  input  wire [7:0]           coder_word,
  // PCM output
  output reg                  pcm_out_ff,
  // Monitor outputs
  output reg                  pwr_on_ff,
  output reg  [NCH:0]         drv_on_ff,
  output reg                  pwr_fault_ff,
  output reg                  drv_fault_ff,
  output reg                  test_fault_ff
);

  // ========================================================================
  // Reset release
  reg         rst_a_ff;
  reg         rst_b_ff;
  wire        rst_n;

  // Asserts at once, releases two edges after the pin
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_a_ff <= 1'h0;
      rst_b_ff <= 1'h0;
    end else begin
      rst_a_ff <= 1'h1;
      rst_b_ff <= rst_a_ff;
    end
  end
  assign rst_n = rst_b_ff;

  // ========================================================================
  // Multiplexer power switch and word drivers
  // Driver NCH carries the identification word
  reg  [NCH:0] cmd_ff;
  reg  [NCH:0] cmd_d_ff;
  reg          pwr_cmd_ff;
  reg          pwr_d_ff;
  wire         mux_load = load_pulse && (src_sel == `PWS_SRC_MUX);
  wire [7:0]   gated_word [0:NCH];
  wire [7:0]   mux_word;
  reg  [7:0]   or_word;
  integer      k;

  genvar i;
  generate
    for (i = 0; i <= NCH; i = i + 1) begin : g_drv
      wire [7:0] src_w;
      if (i == NCH) begin : g_id
        assign src_w = id_word;
      end else begin : g_ch
        assign src_w = chan_data[i*8 +: 8];
      end
      // Bit gates open only behind their driver
      assign gated_word[i] = drv_on_ff[i] ? src_w : `PWS_WORD_RST;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cmd_ff[i]    <= `PWS_BIT_RST;
          cmd_d_ff[i]  <= `PWS_BIT_RST;
          drv_on_ff[i] <= `PWS_BIT_RST;
        end else begin
          cmd_ff[i]    <= rst_n && mux_load && (word_sel == i);
          cmd_d_ff[i]  <= cmd_ff[i];
          drv_on_ff[i] <= cmd_ff[i] && pwr_on_ff;
        end
      end
    end
  endgenerate

  always @* begin
    or_word = `PWS_WORD_RST;
    for (k = 0; k <= NCH; k = k + 1) begin
      or_word = or_word | gated_word[k];
    end
  end
  assign mux_word = or_word;

  // Power only for the load pulse; idle the rest of the word
  // Delayed copy lines up with the driver stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_on_ff  <= `PWS_BIT_RST;
      pwr_cmd_ff <= `PWS_BIT_RST;
      pwr_d_ff   <= `PWS_BIT_RST;
    end else begin
      pwr_on_ff  <= rst_n && mux_load;
      pwr_cmd_ff <= rst_n && mux_load;
      pwr_d_ff   <= pwr_on_ff;
    end
  end

  // ========================================================================
  // Signal flow monitors
  // Continuous check: output must track its command, both ways
  // Drivers lag power by one stage, so compare with the delayed copy
  wire [NCH:0] drv_exp  = cmd_d_ff & {(NCH+1){pwr_d_ff}};
  // Two live drivers at once is a fault as well
  wire [NCH:0] drv_low  = drv_on_ff - {{NCH{1'h0}}, 1'h1};
  wire         drv_many = |(drv_on_ff & drv_low);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_fault_ff <= `PWS_BIT_RST;
      drv_fault_ff <= `PWS_BIT_RST;
    end else begin
      pwr_fault_ff <= pwr_on_ff != pwr_cmd_ff;
      drv_fault_ff <= (drv_on_ff != drv_exp) || drv_many;
    end
  end

  // ========================================================================
  // Output register
  // No reset on purpose: zeros fill the stages as the word leaves
  reg  [7:0]  sreg_ff;
  reg  [7:0]  nxt_sreg;
  wire [7:0]  test_word = test_inv ? ~TEST_WORD : TEST_WORD;
  wire        coder_load = load_pulse && (src_sel == `PWS_SRC_CODER);
  wire        test_load  = load_pulse && (src_sel == `PWS_SRC_TEST);

  always @* begin
    nxt_sreg = sreg_ff;
    if (|drv_on_ff) begin
      nxt_sreg = mux_word;
    end else if (coder_load) begin
      nxt_sreg = coder_word;
    end else if (test_load) begin
      nxt_sreg = test_word;
    end else if (shift_pulse) begin
      nxt_sreg = {sreg_ff[`PWS_MSB-1:0], 1'h0};
    end
  end

  always @(posedge clk) begin
    sreg_ff <= nxt_sreg;
  end

  // ========================================================================
  // NRZ code flip-flop
  // Changes only on a gate pulse, so it holds across loads
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pcm_out_ff <= `PWS_BIT_RST;
    end else if (gate_pulse) begin
      pcm_out_ff <= sreg_ff[`PWS_MSB];
    end
  end

  // ========================================================================
  // Output register self test
  // Shadow copy of the test word checked bit by bit at each gate
  reg  [7:0]  exp_ff;
  reg  [3:0]  chk_cnt_ff;
  wire        chk_live = gate_pulse && (chk_cnt_ff != `PWS_CNT_RST);
  wire        chk_miss = chk_live && (sreg_ff[`PWS_MSB] != exp_ff[`PWS_MSB]);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_ff     <= `PWS_WORD_RST;
      chk_cnt_ff <= `PWS_CNT_RST;
    end else if (test_load) begin
      exp_ff     <= test_word;
      chk_cnt_ff <= `PWS_TEST_CNT;
    end else if (chk_live) begin
      chk_cnt_ff <= chk_cnt_ff - 4'h1;
    end else if (shift_pulse) begin
      exp_ff <= {exp_ff[`PWS_MSB-1:0], 1'h0};
    end
  end

  // Sticky; a mismatch beats a clear in the same cycle
  // Only a true word load clears, so the complement pass keeps a fault
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_fault_ff <= `PWS_BIT_RST;
    end else if (chk_miss) begin
      test_fault_ff <= 1'h1;
    end else if (test_load && !test_inv) begin
      test_fault_ff <= `PWS_BIT_RST;
    end
  end

endmodule

// [bench/pws_prog_model.sv]
/* Programmer model: read-in, read-out and shift pulses.
   Assumes clk is the serializer clock. */
`timescale 1ns/1ps
module pws_prog_model (
  // Clock
  input  wire       clk,
  // Pulses and selects
  output reg        load_pulse,
  output reg        gate_pulse,
  output reg        shift_pulse,
  output reg  [1:0] src_sel,
  output reg  [2:0] word_sel,
  output reg        test_inv
);
  initial {load_pulse, gate_pulse, shift_pulse, src_sel, word_sel, test_inv} = 9'h000;
  // ====
  // Four-cycle read-in, then three quiet cycles before any gate
  task ld(input [1:0] s, input [2:0] w, input i);
    begin
      @(posedge clk);
      {load_pulse, src_sel, word_sel, test_inv} <= {1'b1, s, w, i};
      repeat (4) @(posedge clk);
      load_pulse <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  // Gate then shift; idle cycles set the bit rate
  task bt(input integer g);
    begin
      @(posedge clk);
      gate_pulse <= 1'b1;
      @(posedge clk);
      gate_pulse <= 1'b0;
      shift_pulse <= 1'b1;
      @(posedge clk);
      shift_pulse <= 1'b0;
      repeat (g) @(posedge clk);
    end
  endtask
endmodule

// [bench/pws_serializer_asserts.sv]
/* Checker of the power and driver monitor pins and the PCM pin.
   Assumes loads never meet gates or shifts. */
`timescale 1ns/1ps
module pws_serializer_asserts #(
  parameter NCH  = 4,
  parameter SELW = 3
) (
  // Clock and reset
  input wire            clk,
  input wire            nrst,
  // Programmer
  input wire            load_pulse,
  input wire            gate_pulse,
  input wire [1:0]      src_sel,
  input wire [SELW-1:0] word_sel,
  // Outputs
  input wire            pcm_out_ff,
  input wire            pwr_on_ff,
  input wire [NCH:0]    drv_on_ff,
  input wire            pwr_fault_ff,
  input wire            drv_fault_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire mux_ld = load_pulse && src_sel == 2'h0;
  a_pwr_on_load: assert property (mux_ld |=> pwr_on_ff) else $error("pwr off");
  a_pwr_cause: assert property (pwr_on_ff |-> $past(mux_ld)) else $error("pwr stray");
  a_drv_pick: assert property (pwr_on_ff && word_sel <= NCH |=> drv_on_ff[word_sel])
    else $error("drv off");
  a_drv_refuse: assert property (pwr_on_ff && word_sel > NCH |=> drv_on_ff == '0)
    else $error("drv stray");
  a_drv_one_hot: assert property ($onehot0(drv_on_ff)) else $error("drv many");
  a_drv_needs_pwr: assert property (|drv_on_ff |-> $past(pwr_on_ff)) else $error("no pwr");
  a_pcm_hold: assert property (!gate_pulse |=> $stable(pcm_out_ff)) else $error("pcm moved");
  a_no_fault: assert property (!pwr_fault_ff && !drv_fault_ff) else $error("fault");
endmodule
bind pws_serializer pws_serializer_asserts #(.NCH(NCH), .SELW(SELW)) chk_u (.clk(clk),
  .nrst(nrst), .load_pulse(load_pulse), .gate_pulse(gate_pulse), .src_sel(src_sel),
  .word_sel(word_sel), .pcm_out_ff(pcm_out_ff), .pwr_on_ff(pwr_on_ff),
  .drv_on_ff(drv_on_ff), .pwr_fault_ff(pwr_fault_ff), .drv_fault_ff(drv_fault_ff));

// [bench/pws_serializer_tb.sv]
/* Testbench: programmer model feeds the serializer; bits judged at the pin.
   Assumes the model and checker are compiled first. */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t %h %h", $time, a, b); end end
module pws_serializer_tb;
  localparam [7:0] TW = 8'h3c;
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg  [31:0] chan_data = 32'h8137c46e;
  reg  [7:0]  id_word = 8'hd2;
  reg  [7:0]  coder_word = 8'hb9;
  wire        ld_p, gt_p, sh_p, inv, pcm, tfault;
  wire [1:0]  src;
  wire [2:0]  wsel;
  integer     err_total = 0;
  integer     check_count = 0;
  always #5 clk = ~clk;
  pws_prog_model m_u (.clk(clk), .load_pulse(ld_p), .gate_pulse(gt_p), .shift_pulse(sh_p),
    .src_sel(src), .word_sel(wsel), .test_inv(inv));
  pws_serializer #(.TEST_WORD(TW)) dut_u (.clk(clk), .nrst(nrst), .load_pulse(ld_p),
    .gate_pulse(gt_p), .shift_pulse(sh_p), .src_sel(src), .word_sel(wsel), .test_inv(inv),
    .chan_data(chan_data), .id_word(id_word), .coder_word(coder_word), .pcm_out_ff(pcm),
    .pwr_on_ff(), .drv_on_ff(), .pwr_fault_ff(), .drv_fault_ff(), .test_fault_ff(tfault));
  // ====
  // Load one word, then gate it out; old last bit must survive the load
  task xw(input [1:0] s, input [2:0] w, input i, input [7:0] e, input integer g);
    reg     last;
    integer k;
    begin
      last = pcm;
      m_u.ld(s, w, i);
      `CHK(pcm, last)
      for (k = 7; k >= 0; k--) begin
        m_u.bt(g);
        `CHK(pcm, e[k])
      end
    end
  endtask
  task t_mux;
    integer n;
    begin
      for (n = 0; n < 4; n++) xw(2'h0, n[2:0], 1'b0, chan_data[n*8+:8], 0);
      xw(2'h0, 3'h4, 1'b0, id_word, 0);
    end
  endtask
  // Register emptied by shifting, so refused loads read back zero
  task t_empty;
    begin
      xw(2'h3, 3'h0, 1'b0, 8'h00, 0);
      xw(2'h0, 3'h5, 1'b0, 8'h00, 0);
    end
  endtask
  task t_coder;
    xw(2'h1, 3'h0, 1'b0, coder_word, 6);
  endtask
  task t_test;
    begin
      xw(2'h2, 3'h0, 1'b0, TW, 0);
      xw(2'h2, 3'h0, 1'b1, ~TW, 0);
      `CHK(tfault, 1'b0)
    end
  endtask
  task end_sim;
    begin
      if (err_total == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_mux;
    t_empty;
    t_coder;
    t_test;
    end_sim;
  end
  // Whole run needs well under 1500 cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    end_sim;
  end
endmodule
